// ===== logic/watchdog_sleep_wakeup.sv
// Operation
// - Pending enabled irq, interrupts off: sleep no-op.
// - Irq after sleep: wake, clear watchdog.
// - Enable bit runs watchdog; clearing is permanent.
// - Awake time-out resets the whole device.
// - Asleep time-out wakes and continues execution.
// - Unscaled time-out is nominally 18 ms.
// - Prescaler up to 1:128 via option register.
// - Clear or sleep resets watchdog, and prescaler if assigned to it.
// - Every time-out clears the timeout flag.
// - Prescaler assignment changeable any time.
// - Sleep entry clears watchdog and powerdown flag, sets timeout flag, stops clock.
// - Enabled irq wakes regardless of global enable.
// - Leaving sleep always clears the watchdog.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

module watchdog_sleep_wakeup
   import wdt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `WDT_TIMEOUT_CYCLES
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        sleep_instr,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        irq_pending,
   input  wire logic        global_irq_enable,
   output logic             cpu_clk_en,
   output logic             device_reset,
   output logic             wake_pulse,
   output logic             wake_to_isr
);

   sleep_state_t st;            // Registered state.
   sleep_state_t next_st;       // Next state.

   logic                  req;          // A bus request is present.
   logic                  wr_take;      // Write takes effect this edge.
   logic                  sleep_nop;    // Sleep must behave as a no-op.
   logic                  sleep_go;     // Sleep really enters power-down.
   logic                  wake_now;     // Leaving power-down this edge.
   logic                  assign_wdt;   // Prescaler belongs to the watchdog.
   logic                  assign_flip;  // Assignment is being changed.
   logic                  wdt_clear;    // Clear for the watchdog counter.
   logic                  presc_clear;  // Clear for the shared prescaler.
   logic                  presc_tick;   // Divided count enable.
   logic                  timeout;      // Watchdog time-out pulse.
   logic [`WDT_CNT_W-1:0] wdt_count;    // Current watchdog count.
   logic                  wdt_due;      // Count would expire this edge.

   // Terminal count, mirrored here so the sleep decode can see an expiry
   // coming without reading the counter's own time-out output. Reading
   // that output would close a loop through the counter's clear input,
   // because the time-out is itself held off by a clear.
   localparam logic [`WDT_CNT_W-1:0] WDT_LAST =
      `WDT_CNT_W'(TIMEOUT_CYCLES - 1);

   // Status register image as software sees it.
   function automatic logic [7:0] status_image(input sleep_state_t s);
      logic [7:0] v;
      v = s.status_sw;
      v[`STS_TIMEOUT_BIT] = s.timeout_flag_n;
      v[`STS_POWERDOWN_BIT] = s.powerdown_flag_n;
      status_image = v;
   endfunction

   // Read multiplexer; unmapped addresses read as zero.
   function automatic logic [31:0] read_mux(input logic [3:0] a,
                                            input sleep_state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         `OFS_OPTION: v[7:0] = s.option;
         `OFS_STATUS: v[7:0] = status_image(s);
         `OFS_CONFIG: v[`CFG_ENABLE_BIT] = s.watchdog_enable_cfg;
         default:     v = 32'h0000_0000;
      endcase
      read_mux = v;
   endfunction

   // The slave stalls exactly one cycle, then answers from a register.
   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !st.ack;
   assign avs_readdata    = st.rdata;
   assign wr_take         = avs_write && st.ack && avs_byteenable[0];

   // sleep as no-op
   // A pending enabled source with interrupts off cancels the sleep.
   assign sleep_nop = (st.mode == MODE_AWAKE) && sleep_instr &&
                      irq_pending && !global_irq_enable;
   // An expiry that no clear strobe cancels beats sleep, so the reset it
   // owes is never lost; a clear strobe in the same cycle wins instead.
   assign wdt_due   = st.watchdog_enable_cfg && presc_tick &&
                      (wdt_count == WDT_LAST);
   assign sleep_go  = (st.mode == MODE_AWAKE) && sleep_instr &&
                      !sleep_nop && !(wdt_due && !watchdog_clear_instr);

   // wake regardless of enable
   // Time-out or any enabled source ends power-down.
   assign wake_now = (st.mode == MODE_ASLEEP) && (timeout || irq_pending);

   // live assignment change
   // Swapping the owner restarts the prescaler so no stale phase leaks in.
   assign assign_wdt  = st.option[`OPT_ASSIGN_BIT];
   assign assign_flip = wr_take && (avs_address == `OFS_OPTION) &&
                        (avs_writedata[`OPT_ASSIGN_BIT] != assign_wdt);

   // clear on leaving sleep
   // A time-out clears the counter on its own, so only an irq wake-up
   // needs the strobe here. Feeding wake_now back in would form a loop
   // from the time-out through the clear and back.
   assign wdt_clear   = watchdog_clear_instr || sleep_go ||
                        ((st.mode == MODE_ASLEEP) && irq_pending);
   assign presc_clear = (assign_wdt && wdt_clear) || assign_flip;

   assign cpu_clk_en   = (st.mode == MODE_AWAKE);
   assign device_reset = st.device_reset;
   assign wake_pulse   = st.wake;
   assign wake_to_isr  = st.wake_isr;

   wdt_prescaler u_presc (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clear    (presc_clear),
      .assigned (assign_wdt),
      .ratio    (st.option[`OPT_RATIO_HI:`OPT_RATIO_LO]),
      .tick     (presc_tick)
   );

   wdt_counter #(
      .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
   ) u_cnt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clear   (wdt_clear),
      .enable  (st.watchdog_enable_cfg),
      .tick    (presc_tick),
      .count   (wdt_count),
      .timeout (timeout)
   );

   // Mode, flags and register file; all updates are settled here.
   always_comb begin
      next_st = st;
      next_st.device_reset = 1'b0;
      next_st.wake = 1'b0;
      next_st.wake_isr = 1'b0;
      // Bus handshake: acknowledge the cycle after a request appears.
      next_st.ack = req && !st.ack;
      if (req && !st.ack) begin
         next_st.rdata = read_mux(avs_address, st);
      end
      // Software writes; hardware flags below take precedence.
      if (wr_take) begin
         unique case (avs_address)
            `OFS_OPTION: next_st.option = avs_writedata[7:0];
            `OFS_STATUS: next_st.status_sw = avs_writedata[7:0];
            `OFS_CONFIG: begin
               if (!avs_writedata[`CFG_ENABLE_BIT]) begin
                  next_st.watchdog_enable_cfg = 1'b0;
               end
            end
            default: next_st.option = st.option;
         endcase
      end
      unique case (st.mode)
         MODE_AWAKE: begin
            if (timeout) begin
               next_st.device_reset = 1'b1;
               next_st.timeout_flag_n = 1'b0;
            end else if (sleep_go) begin
               next_st.mode = MODE_ASLEEP;
               next_st.powerdown_flag_n = 1'b0;
               next_st.timeout_flag_n = 1'b1;
            end
         end
         MODE_ASLEEP: begin
            if (timeout) begin
               next_st.mode = MODE_AWAKE;
               next_st.wake = 1'b1;
               next_st.timeout_flag_n = 1'b0;
            end else if (irq_pending) begin
               next_st.mode = MODE_AWAKE;
               next_st.wake = 1'b1;
               // The core runs the next instruction, then the handler.
               next_st.wake_isr = global_irq_enable;
            end
         end
      endcase
   end

   // State register; flags come up as after power-on.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.mode <= MODE_AWAKE;
         st.timeout_flag_n <= 1'b1;
         st.powerdown_flag_n <= 1'b1;
         st.watchdog_enable_cfg <= `CONFIG_EN_RESET;
         st.option <= `OPTION_RESET;
         st.status_sw <= `STATUS_SW_RESET;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Sleep request that must be cancelled.
   sequence nop_seen;
      st.mode == MODE_AWAKE && sleep_instr && irq_pending &&
      !global_irq_enable && !timeout;
   endsequence

   // Sleep request that really enters power-down.
   sequence sleep_seen;
      st.mode == MODE_AWAKE && sleep_instr && !timeout &&
      !(irq_pending && !global_irq_enable);
   endsequence

   // Enabled source seen while asleep, with no time-out competing for
   // the same edge.
   sequence irq_seen;
      st.mode == MODE_ASLEEP && irq_pending && !timeout;
   endsequence

   sleep_nop_a: assert property (nop_seen |=>
      st.mode == MODE_AWAKE && $stable(st.timeout_flag_n) &&
      $stable(st.powerdown_flag_n) && !wake_pulse)
      else $error("Cancelled sleep changed mode or flags.");

   sleep_enter_a: assert property (sleep_seen |=>
      !cpu_clk_en && !st.powerdown_flag_n && st.timeout_flag_n &&
      wdt_count == '0)
      else $error("Sleep entry did not set flags or clear watchdog.");

   irq_wake_a: assert property (
      irq_seen |=>
      cpu_clk_en && wake_pulse && wake_to_isr == $past(global_irq_enable)
      && st.timeout_flag_n && !st.powerdown_flag_n)
      else $error("Pending irq did not wake the core correctly.");

   clear_instr_a: assert property (watchdog_clear_instr |=>
      wdt_count == '0 && !device_reset)
      else $error("Clear instruction did not restart the watchdog.");

   awake_reset_a: assert property (
      st.mode == MODE_AWAKE && timeout |=>
      device_reset && !st.timeout_flag_n ##1 !device_reset)
      else $error("Awake time-out did not give one reset pulse.");

   sleep_wake_a: assert property (
      st.mode == MODE_ASLEEP && timeout |=>
      wake_pulse && !device_reset && cpu_clk_en && !st.timeout_flag_n)
      else $error("Time-out in sleep did not wake without reset.");

   wake_clear_a: assert property (wake_now |=> wdt_count == '0)
      else $error("Watchdog not cleared on leaving sleep.");

   disable_perm_a: assert property (
      !st.watchdog_enable_cfg |=> !st.watchdog_enable_cfg && !timeout
      && wdt_count == '0)
      else $error("Disabled watchdog came back or counted.");

   flag_timeout_a: assert property (timeout |=>
      !st.timeout_flag_n)
      else $error("Time-out left the timeout flag set.");

   // no-op keeps count
   // A cancelled sleep must leave the watchdog counting on as before.
   nop_count_a: assert property (
      st.mode == MODE_AWAKE && sleep_instr && irq_pending &&
      !global_irq_enable && !watchdog_clear_instr && !timeout &&
      st.watchdog_enable_cfg && presc_tick |=>
      wdt_count == $past(wdt_count) + `WDT_CNT_W'(1))
      else $error("Cancelled sleep cleared the watchdog.");

   // flag falls on time-out
   // Nothing but a time-out may pull the timeout flag low.
   flag_cause_a: assert property (
      $fell(st.timeout_flag_n) |-> $past(timeout))
      else $error("Timeout flag fell without a time-out.");

   // powerdown flag on entry
   // Only a sleep that really enters power-down clears this flag; that
   // is what lets software tell a cancelled sleep from a real one.
   pd_cause_a: assert property (
      $fell(st.powerdown_flag_n) |-> $past(sleep_go))
      else $error("Powerdown flag fell without a real sleep.");

   // reset only while awake
   // A time-out in power-down must end in a wake-up, never a reset.
   reset_awake_a: assert property (
      device_reset |-> $past(st.mode == MODE_AWAKE))
      else $error("Device reset issued from power-down.");

   isr_with_wake_a: assert property (
      wake_to_isr |-> wake_pulse)
      else $error("Handler entry flagged without a wake-up.");

   // Each wake-up is a single-cycle strobe for the core.
   wake_pulse_a: assert property (wake_pulse |=> !wake_pulse)
      else $error("Wake strobe stood for more than one cycle.");

   // option write lands
   // Assignment and ratio change on the very edge the write is taken.
   option_write_a: assert property (
      wr_take && avs_address == `OFS_OPTION |=>
      st.option == $past(avs_writedata[7:0]))
      else $error("Option write did not land.");

   // The slave stalls a fresh request once and answers one cycle later.
   // A master must still wait on waitrequest, not on a fixed latency.
   bus_stall_a: assert property (
      (avs_read || avs_write) && !st.ack |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("Bus request not answered after one wait cycle.");

endmodule
`default_nettype wire

// ===== logic/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Register byte offsets on the slave port.
`define OFS_OPTION        4'h0
`define OFS_STATUS        4'h4
`define OFS_CONFIG        4'h8

// Field positions in the option control register.
`define OPT_ASSIGN_BIT    3
`define OPT_RATIO_HI      2
`define OPT_RATIO_LO      0

// Field positions in the status register.
`define STS_TIMEOUT_BIT   4
`define STS_POWERDOWN_BIT 3

// Field position in the configuration register.
`define CFG_ENABLE_BIT    0

// Reset values.
`define OPTION_RESET      8'h00
`define STATUS_SW_RESET   8'h00
`define CONFIG_EN_RESET   1'b1

// Timing: nominal time-out period and system clock rate.
`define WDT_PERIOD_MS     18
`define CLK_SYS_HZ        20000000
`define WDT_TIMEOUT_CYCLES ((`WDT_PERIOD_MS * `CLK_SYS_HZ) / 1000)

// Width of the watchdog counter, large enough for the time-out count.
`define WDT_CNT_W         20
// Width of the shared prescaler, enough for a 1:128 division.
`define PRESC_W           7

`endif

// ===== logic/wdt_pkg.sv
`include "wdt_cfg.svh"

package wdt_pkg;

   // Operating mode of the processor as seen by the watchdog.
   typedef enum logic {
      MODE_AWAKE,
      MODE_ASLEEP
   } mode_t;

   // Whole state of the sleep and register block.
   typedef struct packed {
      mode_t      mode;
      logic       timeout_flag_n;
      logic       powerdown_flag_n;
      logic       watchdog_enable_cfg;
      logic [7:0] option;
      logic [7:0] status_sw;
      logic       ack;
      logic [31:0] rdata;
      logic       device_reset;
      logic       wake;
      logic       wake_isr;
   } sleep_state_t;

   // Whole state of the shared prescaler.
   typedef struct packed {
      logic [`PRESC_W-1:0] count;
   } presc_state_t;

   // Whole state of the watchdog counter.
   typedef struct packed {
      logic [`WDT_CNT_W-1:0] count;
   } wdt_cnt_state_t;

endpackage

// ===== logic/wdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_prescaler
   import wdt_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       assigned,
   input  wire logic [2:0] ratio,
   output logic            tick
);

   presc_state_t st;       // Registered state.
   presc_state_t next_st;  // Next state.

   // Low bits that must all be ones for a divided tick.
   function automatic logic [`PRESC_W-1:0] ratio_mask(input logic [2:0] r);
      ratio_mask = `PRESC_W'((8'h01 << r) - 8'h01);
   endfunction

   // power-of-two division
   // Without assignment every cycle is a tick, so the bare period applies.
   assign tick = assigned ?
                 ((st.count & ratio_mask(ratio)) == ratio_mask(ratio)) : 1'b1;

   // The count restarts on clear so a clear always buys a full period.
   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.count = '0;
      end else if (assigned) begin
         next_st.count = st.count + `PRESC_W'(1);
      end
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ratio_one_a: assert property (assigned && ratio == 3'h0 |-> tick)
      else $error("Ratio 1:1 must tick every cycle.");

   ratio_two_a: assert property (
      assigned && ratio == 3'h1 && tick && !clear ##1 assigned && ratio == 3'h1
      |-> !tick)
      else $error("Ratio 1:2 ticked on two adjacent cycles.");

endmodule
`default_nettype wire

// ===== logic/wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_counter
   import wdt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `WDT_TIMEOUT_CYCLES
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  clear,
   input  wire logic                  enable,
   input  wire logic                  tick,
   output logic [`WDT_CNT_W-1:0]      count,
   output logic                       timeout
);

   wdt_cnt_state_t st;       // Registered state.
   wdt_cnt_state_t next_st;  // Next state.

   // Terminal value of the count, one below the time-out count.
   localparam logic [`WDT_CNT_W-1:0] LAST = `WDT_CNT_W'(TIMEOUT_CYCLES - 1);

   assign count = st.count;

   // base time-out period
   // A clear in the same cycle suppresses the time-out, never the reverse.
   assign timeout = enable && tick && !clear && (st.count == LAST);

   // Counting advances only on prescaler ticks.
   always_comb begin
      next_st = st;
      if (clear || timeout || !enable) begin
         next_st.count = '0;
      end else if (tick) begin
         next_st.count = st.count + `WDT_CNT_W'(1);
      end
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   count_bound_a: assert property (st.count <= LAST)
      else $error("Watchdog count passed its terminal value.");

endmodule
`default_nettype wire

// ===== verification/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural processor core: issues sleep and watchdog clear strobes and
// presents the interrupt lines that the wake-up logic watches.
module core_model (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic cpu_clk_en,
   output logic      sleep_instr,
   output logic      watchdog_clear_instr,
   output logic      irq_pending,
   output logic      global_irq_enable
);

   // All strobes idle and interrupts quiet from time zero.
   initial begin
      sleep_instr          = 1'b0;
      watchdog_clear_instr = 1'b0;
      irq_pending          = 1'b0;
      global_irq_enable    = 1'b0;
   end

   // One-cycle instruction strobe, clear when clr is set, else sleep.
   task automatic strobe(input bit clr);
      @(posedge clk_sys);
      // stopped clock, no fetch
      // A core held in reset or with its clock stopped executes nothing.
      if (rst === 1'b0 && cpu_clk_en === 1'b1) begin
         watchdog_clear_instr <= clr;
         sleep_instr          <= !clr;
         @(posedge clk_sys);
         watchdog_clear_instr <= 1'b0;
         sleep_instr          <= 1'b0;
      end
   endtask

   // Level change on the pending line and the global enable.
   task automatic set_irq(input logic p, input logic g);
      @(posedge clk_sys);
      irq_pending       <= p;
      global_irq_enable <= g;
   endtask

endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

// Counts the comparison and reports a mismatch at once.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb
   import wdt_pkg::*;
;
   // Short time-out keeps the run small; the time-out windows derive from it.
   localparam int TMO = 16;

   logic        clk_sys;
   logic        rst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   wire logic   sleep_instr;
   wire logic   watchdog_clear_instr;
   wire logic   irq_pending;
   wire logic   global_irq_enable;
   logic        cpu_clk_en;
   logic        device_reset;
   logic        wake_pulse;
   logic        wake_to_isr;
   int          bad_count = 0;
   int          n_tests   = 0;
   int          cyc       = 0;
   int          rst_cnt   = 0;
   int          n;
   int          lo;
   int          hi;
   int          r0;
   logic [7:0]  d;
   logic [7:0]  s0;

   watchdog_sleep_wakeup #(.TIMEOUT_CYCLES(TMO)) dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
      .irq_pending(irq_pending), .global_irq_enable(global_irq_enable),
      .cpu_clk_en(cpu_clk_en), .device_reset(device_reset),
      .wake_pulse(wake_pulse), .wake_to_isr(wake_to_isr)
   );

   core_model core (
      .clk_sys(clk_sys), .rst(rst), .cpu_clk_en(cpu_clk_en),
      .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
      .irq_pending(irq_pending), .global_irq_enable(global_irq_enable)
   );

   // 20 MHz system clock.
   always #25 clk_sys = ~clk_sys;

   // Every device reset pulse is counted so quiet stretches can be proven.
   always @(negedge clk_sys) begin
      if (device_reset === 1'b1) begin
         rst_cnt++;
      end
   end

   // Hang guard: well above the roughly 4600 cycles the tests need.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One Avalon transfer; held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] wd, input logic [3:0] be,
                      output logic [7:0] rd);
      @(posedge clk_sys);
      avs_address    <= a;
      avs_writedata  <= {24'h00_0000, wd};
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      // Only the hang guard ends this wait; no latency is assumed.
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bus(1'b1, a, v, 4'hF, d);
   endtask

   // Reads a register and compares the masked byte.
   task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, a, 8'h00, 4'hF, r);
      `CHK(r & m, e)
   endtask

   // Counts cycles until device_reset (rsel) or wake_pulse shows.
   task automatic wait_on(input bit rsel, input int lim, output int k);
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while ((rsel ? device_reset : wake_pulse) !== 1'b1 && k < lim);
   endtask

   initial begin
      clk_sys        = 1'b0;
      rst            = 1'b1;
      avs_address    = 4'h0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, read-only flags, byte enable and unmapped space.
      rdc(4'h4, 8'hFF, 8'h18); // flags idle high
      wr(4'h4, 8'hE7);
      rdc(4'h4, 8'hFF, 8'hFF); // flags not writable
      rdc(4'h0, 8'hFF, 8'h00); // option reset
      bus(1'b1, 4'h0, 8'hFF, 4'h0, d);
      rdc(4'h0, 8'hFF, 8'h00); // masked write ignored
      rdc(4'h8, 8'hFF, 8'h01); // enabled by default
      rdc(4'hC, 8'hFF, 8'h00); // unmapped reads zero
      // Pending irq with interrupts off turns sleep into a no-op.
      core.strobe(1'b1);
      bus(1'b0, 4'h4, 8'h00, 4'hF, s0);
      core.set_irq(1'b1, 1'b0);
      core.strobe(1'b0);
      @(negedge clk_sys);
      `CHK(cpu_clk_en, 1'b1) // core keeps running
      rdc(4'h4, 8'hFF, s0); // flags untouched
      `CHK(s0[3], 1'b1) // powerdown flag shows no-op
      // Real sleep, then an irq wakes it with either global enable.
      for (int g = 0; g < 2; g++) begin
         core.set_irq(1'b0, 1'b0);
         core.strobe(1'b1);
         core.strobe(1'b0);
         @(negedge clk_sys);
         `CHK(cpu_clk_en, 1'b0) // clock stopped
         rdc(4'h4, 8'h18, 8'h10); // flags on entry
         r0 = rst_cnt;
         core.set_irq(1'b1, g[0]);
         wait_on(1'b0, 20, n);
         `CHK(wake_to_isr, g[0]) // isr only with enable
         `CHK(n < 4, 1'b1) // immediate wake
         repeat (13) @(negedge clk_sys);
         `CHK(rst_cnt, r0) // watchdog cleared on exit
         `CHK(cpu_clk_en, 1'b1) // running again
      end
      // Awake time-out with the prescaler on the other timer.
      core.set_irq(1'b0, 1'b0);
      wr(4'h0, 8'h07);
      core.strobe(1'b1);
      wait_on(1'b1, 5000, n);
      `CHK(n >= TMO - 2 && n <= TMO + 5, 1'b1) // base period
      rdc(4'h4, 8'h10, 8'h00); // timeout flag cleared
      // Every ratio, reassigned while the watchdog keeps running.
      for (int k = 0; k < 8; k++) begin
         wr(4'h0, {4'h0, 1'b1, k[2:0]});
         core.strobe(1'b1);
         wait_on(1'b1, 5000, n);
         lo = (TMO << k) - (2 << k);
         hi = (TMO << k) + (1 << k) + 4;
         `CHK(n >= lo && n <= hi, 1'b1)
      end
      // A time-out while asleep wakes without a device reset.
      wr(4'h0, 8'h00);
      core.strobe(1'b1);
      core.strobe(1'b0);
      r0 = rst_cnt;
      wait_on(1'b0, 100, n);
      `CHK(n >= TMO - 2 && n <= TMO + 5, 1'b1) // wake on time-out
      `CHK(rst_cnt, r0) // no reset while asleep
      rdc(4'h4, 8'h18, 8'h00); // both flags low
      // Regular clears hold the watchdog off.
      r0 = rst_cnt;
      repeat (8) begin
         core.strobe(1'b1);
         repeat (10) @(posedge clk_sys);
      end
      `CHK(rst_cnt, r0) // clear prevents time-out
      // Disabling is permanent; writing one back does nothing.
      core.strobe(1'b1);
      wr(4'h8, 8'h00);
      r0 = rst_cnt;
      repeat (100) @(posedge clk_sys);
      wr(4'h8, 8'h01);
      rdc(4'h8, 8'hFF, 8'h00); // stays disabled
      repeat (100) @(posedge clk_sys);
      `CHK(rst_cnt, r0) // no time-out when off
      print_verdict();
   end

endmodule
`default_nettype wire
